// ===== logic/idc_io_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "idc_defines.svh"

module idc_io_top
  import idc_pkg::*;
#(
  parameter int NCH = `IDC_CHANNELS,
  parameter int NGR = `IDC_GROUPS,
  parameter int TW  = `IDC_TIMER_WIDTH
)
(
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst_b,
  // Field channel pins (open drain driver)
  input  wire logic [NCH-1:0]       field_channel_pin_in,
  output logic      [NCH-1:0]       field_channel_pin_out,
  output logic      [NCH-1:0]       field_channel_pin_oe,
  // Front panel test plugs
  input  wire logic [NCH-1:0]       test_plug_in,
  // Output driver fault sources
  input  wire logic [NCH-1:0]       drv_short,
  input  wire logic [NGR-1:0]       drv_overvolt,
  input  wire logic [NGR-1:0]       drv_overtemp,
  // Build straps
  input  wire logic [3:0]           mux_select,
  input  wire logic                 irq_level_five,
  input  wire logic [1:0]           pp_irq_route,
  // Host configuration
  input  wire logic [NGR-1:0]       grp_dir_out,
  input  wire logic [NCH-1:0]       host_out_level,
  input  wire logic [15:0]          edge_enable,
  input  wire logic [15:0]          edge_rising,
  input  wire logic [1:0]           int_ack,
  // Timer counters
  input  wire logic [1:0]           timer_count_in,
  input  wire logic [1:0]           timer_clear,
  output logic      [TW-1:0]        timer_value_one,
  output logic      [TW-1:0]        timer_value_two,
  // Pulse processor access
  input  wire logic [1:0]           pp_run,
  input  wire logic [1:0]           pp_tbl_we,
  input  wire logic [3:0]           pp_tbl_addr,
  input  wire idc_entry_s           pp_tbl_data,
  input  wire logic [2:0]           pp_rd_sel,
  output logic      [15:0]          pp_count_one,
  output logic      [15:0]          pp_count_two,
  // Controller ports and status
  output logic      [NCH-1:0]       chan_read,
  output logic      [7:0]           edge_input_controller_one_port_a,
  output logic      [7:0]           edge_input_controller_two_port_a,
  output logic      [3:0]           edge_input_controller_one_fault,
  output logic      [3:0]           edge_input_controller_two_fault,
  output logic      [1:0]           int_pending,
  output logic                      host_irq1_b,
  output logic                      host_irq5_b,
  // Front panel LEDs
  output logic      [NCH-1:0]       led_green,
  output logic      [NCH-1:0]       led_red
);

  typedef struct packed
  {
    logic [`IDC_SY_WIDTH-1:0]  s1;
    logic [`IDC_SY_WIDTH-1:0]  s2;
    logic [15:0]               port_a;
    logic [1:0]                int_pend;
    logic [1:0]                tmr_prev;
    logic [1:0][TW-1:0]        tmr;
    logic [NCH-1:0]            pin_out;
    logic [NCH-1:0]            pin_oe;
    logic [NCH-1:0]            chan_read;
    logic [NCH-1:0]            led_g;
    logic [NCH-1:0]            led_r;
    logic [NGR-1:0]            grp_fault;
    logic                      irq1_b;
    logic                      irq5_b;
  } idc_top_s;

  idc_top_s r;
  idc_top_s next_r;

  logic [1:0][7:0] pp_out;
  logic [1:0]      pp_irq;
  logic [1:0][15:0] pp_rd;
  logic [1:0][7:0] pp_chan_in;

  // Synchronised views of the second flip-flop stage
  logic [NCH-1:0] pin_s;
  logic [NCH-1:0] plug_s;
  logic [NCH-1:0] short_s;
  logic [NGR-1:0] ovolt_s;
  logic [NGR-1:0] otemp_s;
  logic [3:0]     mux_s;
  logic           lvl5_s;
  logic [1:0]     route_s;
  logic [1:0]     tmr_s;

  assign pin_s   = r.s2[`IDC_SY_PIN +: NCH];
  assign plug_s  = r.s2[`IDC_SY_PLUG +: NCH];
  assign short_s = r.s2[`IDC_SY_SHORT +: NCH];
  assign ovolt_s = r.s2[`IDC_SY_OVOLT +: NGR];
  assign otemp_s = r.s2[`IDC_SY_OTEMP +: NGR];
  assign mux_s   = r.s2[`IDC_SY_MUX +: 4];
  assign lvl5_s  = r.s2[`IDC_SY_LVL5];
  assign route_s = r.s2[`IDC_SY_ROUTE +: 2];
  assign tmr_s   = r.s2[`IDC_SY_TMR +: 2];

  // Index of the multiplexer serving a group, or -1 for host driven groups
  function automatic int mux_of(input int g);
    case (g)
      0:       mux_of = 0;
      1:       mux_of = 1;
      4:       mux_of = 2;
      5:       mux_of = 3;
      default: mux_of = -1;
    endcase
  endfunction

  // Output direction of a group
  function automatic logic grp_is_out(input int g, input logic [3:0] mux,
                                      input logic [NGR-1:0] host_dir);
    int m;
    m = mux_of(g);
    if (m >= 0)
    begin
      grp_is_out = mux[m];
    end
    else
    begin
      grp_is_out = host_dir[g];
    end
  endfunction

  // Pulse units see the field level of their own channels
  assign pp_chan_in[0] = pin_s[7:0];
  assign pp_chan_in[1] = pin_s[23:16];

  // Two pulse processors, channels 1-8 and 17-24
  generate
    for (genvar k = 0; k < 2; k++)
    begin : g_pp
      idc_pulse_proc u_pp
      (
        .clk       (clk),
        .rst_b     (rst_b),
        .run       (pp_run[k]),
        .tbl_we    (pp_tbl_we[k]),
        .tbl_addr  (pp_tbl_addr),
        .tbl_data  (pp_tbl_data),
        .rd_sel    (pp_rd_sel),
        .chan_in   (pp_chan_in[k]),
        .pulse_out (pp_out[k]),
        .irq       (pp_irq[k]),
        .rd_count  (pp_rd[k])
      );
    end
  endgenerate

  // Channel, fault, LED, edge, interrupt and timer logic
  always_comb
  begin
    logic [NGR-1:0] g_out;
    logic [NGR-1:0] g_zero;
    logic [NGR-1:0] g_shut;
    logic [NCH-1:0] drive;
    logic [NCH-1:0] cfault;
    logic [15:0]    rise;
    logic [15:0]    fall;
    logic [1:0][7:0] ev;
    logic           any_int;
    int             g;
    int             m;
    g_out  = '0;
    g_zero = '1;
    g_shut = '0;
    drive  = '0;
    cfault = '0;
    rise   = '0;
    fall   = '0;
    ev     = '0;
    any_int = 1'b0;
    g      = 0;
    m      = 0;
    next_r = r;

    // Two stage synchroniser on every off-domain input
    next_r.s1 = {timer_count_in, pp_irq_route, irq_level_five, mux_select,
                 drv_overtemp, drv_overvolt, drv_short, test_plug_in,
                 field_channel_pin_in};
    next_r.s2 = r.s1;

    // Group direction and shutdown
    for (int i = 0; i < NGR; i++)
    begin
      g_out[i]  = grp_is_out(i, mux_s, grp_dir_out);
      g_shut[i] = otemp_s[i] | ovolt_s[i];
    end

    // Data source of each channel
    for (int c = 0; c < NCH; c++)
    begin
      g = c / `IDC_GROUP_SIZE;
      m = mux_of(g);
      if (m >= 0)
      begin
        drive[c] = pp_out[m / 2][(m % 2) * 4 + (c % 4)];
      end
      else
      begin
        drive[c] = host_out_level[c];
      end
      if (drive[c])
      begin
        g_zero[g] = 1'b0;
      end
    end

    // Per channel pin drive, readback, faults and LEDs
    next_r.grp_fault = '0;
    for (int c = 0; c < NCH; c++)
    begin
      g = c / `IDC_GROUP_SIZE;
      next_r.pin_out[c] = drive[c] & ~g_shut[g];
      next_r.pin_oe[c]  = g_out[g];
      cfault[c] = g_out[g] & ~plug_s[c] & (short_s[c] | g_shut[g]);
      next_r.chan_read[c] = (!g_out[g] && plug_s[c]) ? 1'b1 : pin_s[c];
      if (cfault[c])
      begin
        next_r.grp_fault[g] = 1'b1;
      end
      next_r.led_r[c] = cfault[c];
      if (g_out[g])
      begin
        next_r.led_g[c] = ~cfault[c] & (drive[c] | (g_zero[g] & pin_s[c]));
      end
      else
      begin
        next_r.led_g[c] = next_r.chan_read[c];
      end
    end

    // Controller port A: channels 1-8 and 17-24, bit seven may carry pulse irq
    next_r.port_a[7:0]  = next_r.chan_read[7:0];
    next_r.port_a[15:8] = next_r.chan_read[23:16];
    if (route_s[0])
    begin
      next_r.port_a[`IDC_PORT_A_BIT_SEVEN] = pp_irq[0];
    end
    if (route_s[1])
    begin
      next_r.port_a[8 + `IDC_PORT_A_BIT_SEVEN] = pp_irq[1];
    end

    // Edge events per configured polarity
    rise = next_r.port_a & ~r.port_a;
    fall = ~next_r.port_a & r.port_a;
    for (int k = 0; k < 2; k++)
    begin
      for (int b = 0; b < 8; b++)
      begin
        ev[k][b] = edge_enable[k * 8 + b] &
                   (edge_rising[k * 8 + b] ? rise[k * 8 + b] : fall[k * 8 + b]);
      end
      next_r.int_pend[k] = (r.int_pend[k] & ~int_ack[k]) | (|ev[k]);
    end

    // Merge and route to the host interrupt line, never masked
    any_int = |next_r.int_pend;
    next_r.irq1_b = ~(any_int & ~lvl5_s);
    next_r.irq5_b = ~(any_int & lvl5_s);

    // Timer counters on synchronised count edges
    next_r.tmr_prev = tmr_s;
    for (int k = 0; k < 2; k++)
    begin
      if (timer_clear[k])
      begin
        next_r.tmr[k] = '0;
      end
      else if (tmr_s[k] && !r.tmr_prev[k])
      begin
        next_r.tmr[k] = r.tmr[k] + TW'(1);
      end
    end
  end

  // State register
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      r        <= '0;
      r.irq1_b <= `IDC_RST_IRQ_B;
      r.irq5_b <= `IDC_RST_IRQ_B;
    end
    else
    begin
      r <= next_r;
    end
  end

  // Outputs straight from the state register, pulse counts from the pulse units
  assign field_channel_pin_out            = r.pin_out;
  assign field_channel_pin_oe             = r.pin_oe;
  assign chan_read                        = r.chan_read;
  assign edge_input_controller_one_port_a = r.port_a[7:0];
  assign edge_input_controller_two_port_a = r.port_a[15:8];
  assign edge_input_controller_one_fault  = r.grp_fault[3:0];
  assign edge_input_controller_two_fault  = r.grp_fault[7:4];
  assign int_pending                      = r.int_pend;
  assign host_irq1_b                      = r.irq1_b;
  assign host_irq5_b                      = r.irq5_b;
  assign timer_value_one                  = r.tmr[0];
  assign timer_value_two                  = r.tmr[1];
  assign led_green                        = r.led_g;
  assign led_red                          = r.led_r;
  assign pp_count_one                     = pp_rd[0];
  assign pp_count_two                     = pp_rd[1];

endmodule
`default_nettype wire

// ===== logic/idc_defines.svh
`ifndef IDC_DEFINES_SVH
`define IDC_DEFINES_SVH

// Board geometry
`define IDC_CHANNELS        32
`define IDC_GROUP_SIZE      4
`define IDC_GROUPS          8
`define IDC_PORT_WIDTH      8
`define IDC_FAULT_BITS      4
`define IDC_PORT_A_BIT_SEVEN 7

// Pulse processor geometry
`define IDC_PP_CHANNELS     8
`define IDC_PP_CHAN_W       3
`define IDC_TABLE_DEPTH     16
`define IDC_TABLE_IDX_W     4
`define IDC_ALU_WIDTH       16
`define IDC_TIMER_WIDTH     16

// Clock and input rate limits
`define IDC_CLK_HZ          40000000
`define IDC_TIMER_IN_MAX_HZ 3000000
`define IDC_PP_COUNT_MAX_HZ 100000
`define IDC_TIMER_MIN_HALF_CYCLES ((`IDC_CLK_HZ / `IDC_TIMER_IN_MAX_HZ) / 2)

// Field positions in the synchroniser vector
`define IDC_SY_PIN          0
`define IDC_SY_PLUG         32
`define IDC_SY_SHORT        64
`define IDC_SY_OVOLT        96
`define IDC_SY_OTEMP        104
`define IDC_SY_MUX          112
`define IDC_SY_LVL5         116
`define IDC_SY_ROUTE        117
`define IDC_SY_TMR          119
`define IDC_SY_WIDTH        121

// Reset values
`define IDC_RST_IRQ_B       1'b1

`endif

// ===== logic/idc_pkg.sv
package idc_pkg;

  // Operating mode of one process table entry
  typedef enum logic [1:0]
  {
    idc_mode_plain = 2'b00,
    idc_mode_pwm   = 2'b01,
    idc_mode_count = 2'b10,
    idc_mode_off   = 2'b11
  } idc_mode_e;

  // One process table entry
  typedef struct packed
  {
    logic        en;
    idc_mode_e   mode;
    logic [2:0]  chan;
    logic [15:0] period;
    logic [15:0] duty;
  } idc_entry_s;

  // Table scanner state
  typedef enum logic [0:0]
  {
    idc_pp_halt = 1'b0,
    idc_pp_run  = 1'b1
  } idc_pp_state_e;

endpackage

// ===== logic/idc_pulse_proc.sv
`timescale 1ns/10ps
`default_nettype none
`include "idc_defines.svh"

module idc_pulse_proc
  import idc_pkg::*;
#(
  parameter int CH    = `IDC_PP_CHANNELS,
  parameter int DEPTH = `IDC_TABLE_DEPTH,
  parameter int IDX_W = `IDC_TABLE_IDX_W,
  parameter int W     = `IDC_ALU_WIDTH
)
(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_b,
  // Control and table access
  input  wire logic             run,
  input  wire logic             tbl_we,
  input  wire logic [IDX_W-1:0] tbl_addr,
  input  wire idc_entry_s       tbl_data,
  input  wire logic [2:0]       rd_sel,
  // Channel side
  input  wire logic [CH-1:0]    chan_in,
  output logic      [CH-1:0]    pulse_out,
  output logic                  irq,
  output logic      [W-1:0]     rd_count
);

  typedef struct packed
  {
    idc_pp_state_e                st;
    logic [IDX_W-1:0]             idx;
    idc_entry_s [DEPTH-1:0]       tbl;
    logic [CH-1:0][W-1:0]         cnt;
    logic [CH-1:0]                last_in;
    logic [CH-1:0]                pout;
    logic                         irq;
    logic [W-1:0]                 rd;
  } idc_pp_reg_s;

  idc_pp_reg_s r;
  idc_pp_reg_s next_r;

  // Table scan, ALU step and channel update
  always_comb
  begin
    idc_entry_s e;
    logic [W-1:0] sum;
    e = r.tbl[r.idx];
    sum = '0;
    next_r = r;
    next_r.irq = 1'b0;
    if (tbl_we)
    begin
      next_r.tbl[tbl_addr] = tbl_data;
    end
    case (r.st)
      idc_pp_halt:
      begin
        next_r.idx = '0;
        if (run)
        begin
          next_r.st = idc_pp_run;
        end
      end
      idc_pp_run:
      begin
        if (!run)
        begin
          next_r.st = idc_pp_halt;
        end
        else if (r.idx == IDX_W'(DEPTH - 1))
        begin
          next_r.idx = '0;
        end
        else
        begin
          next_r.idx = r.idx + 1'b1;
        end
        if (e.en)
        begin
          sum = r.cnt[e.chan] + W'(1);
          case (e.mode)
            idc_mode_plain:
            begin
              next_r.pout[e.chan] = |e.duty;
            end
            idc_mode_pwm:
            begin
              next_r.cnt[e.chan] = (sum >= e.period) ? '0 : sum;
              next_r.pout[e.chan] = (r.cnt[e.chan] < e.duty);
            end
            idc_mode_count:
            begin
              next_r.last_in[e.chan] = chan_in[e.chan];
              if (chan_in[e.chan] && !r.last_in[e.chan])
              begin
                next_r.cnt[e.chan] = sum;
                next_r.irq = (sum == e.period);
              end
            end
            idc_mode_off:
            begin
              next_r.pout[e.chan] = 1'b0;
            end
            default:
            begin
              next_r.pout[e.chan] = 1'b0;
            end
          endcase
        end
      end
      default:
      begin
        next_r.st = idc_pp_halt;
      end
    endcase
    next_r.rd = r.cnt[rd_sel];
  end

  // State register
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      r <= '0;
    end
    else
    begin
      r <= next_r;
    end
  end

  // Outputs straight from the state register
  assign pulse_out = r.pout;
  assign irq       = r.irq;
  assign rd_count  = r.rd;

endmodule
`default_nettype wire

// ===== dv/idc_io_chk.sv
`timescale 1ns/10ps
`default_nettype none
module idc_io_chk
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst_b,
  // Field, plug and fault inputs
  input wire logic [31:0] field_channel_pin_in,
  input wire logic [31:0] field_channel_pin_oe,
  input wire logic [31:0] test_plug_in,
  input wire logic [7:0]  drv_overtemp,
  // Straps and host controls
  input wire logic [3:0]  mux_select,
  input wire logic        irq_level_five,
  input wire logic [7:0]  grp_dir_out,
  input wire logic [1:0]  int_ack,
  // Observed outputs
  input wire logic [31:0] chan_read,
  input wire logic [3:0]  edge_input_controller_one_fault,
  input wire logic [1:0]  int_pending,
  input wire logic        host_irq1_b,
  input wire logic        host_irq5_b,
  input wire logic [31:0] led_green,
  input wire logic [31:0] led_red
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  // Host request lines follow the merged pending flags and the strap
  property p_irq_one;
    $stable(irq_level_five)[*4] |-> host_irq1_b == !((|int_pending) && !irq_level_five);
  endproperty
  a_irq_one: assert property (p_irq_one) else $error("level one request wrong");
  property p_irq_five;
    $stable(irq_level_five)[*4] |-> host_irq5_b == !((|int_pending) && irq_level_five);
  endproperty
  a_irq_five: assert property (p_irq_five) else $error("level five request wrong");
  // Pending flags drop only after an acknowledge
  property p_sticky;
    (~int_pending & $past(int_pending) & ~$past(int_ack)) == 2'h0;
  endproperty
  a_sticky: assert property (p_sticky) else $error("pending lost without ack");
  // Select held low turns the first pulse group into inputs
  property p_mux_in;
    (!mux_select[0])[*4] |-> field_channel_pin_oe[3:0] == 4'h0;
  endproperty
  a_mux_in: assert property (p_mux_in) else $error("muxed group still drives");
  // A bicolour lamp is never lit both ways
  property p_led;
    (led_green & led_red) == 32'h0;
  endproperty
  a_led: assert property (p_led) else $error("lamp green and red");
  // Overtemperature on an output group raises its flag
  property p_otemp;
    (drv_overtemp[2] && grp_dir_out[2] && test_plug_in[11:8] == 4'h0)[*4]
      |-> edge_input_controller_one_fault[2];
  endproperty
  a_otemp: assert property (p_otemp) else $error("group flag missing");
  // Plugged input channel reads one
  property p_plug;
    (test_plug_in[12] && !grp_dir_out[3])[*4] |-> chan_read[12];
  endproperty
  a_plug: assert property (p_plug) else $error("plugged input not one");
  // Steady unplugged input is read back as it stands
  property p_read;
    (!grp_dir_out[2] && !test_plug_in[8] && $stable(field_channel_pin_in[8]))[*4]
      |-> chan_read[8] == field_channel_pin_in[8];
  endproperty
  a_read: assert property (p_read) else $error("input readback wrong");
  // Main scenarios reached
  c_one: cover property (!host_irq1_b);
  c_five: cover property (!host_irq5_b);
  c_flag: cover property (edge_input_controller_one_fault[2]);
endmodule
bind idc_io_top idc_io_chk u_chk (.clk, .rst_b, .field_channel_pin_in, .field_channel_pin_oe,
  .test_plug_in, .drv_overtemp, .mux_select, .irq_level_five, .grp_dir_out, .int_ack,
  .chan_read, .edge_input_controller_one_fault, .int_pending, .host_irq1_b, .host_irq5_b,
  .led_green, .led_red);
`default_nettype wire

// ===== dv/idc_field_model.sv
`timescale 1ns/10ps
`default_nettype none
module idc_field_model
(
  // Board drive side
  input  wire logic [31:0] drv_out,
  input  wire logic [31:0] drv_oe,
  // Field feed and resolved pins
  input  wire logic [31:0] ext_level,
  output logic      [31:0] pin_level
);
  // Open drain: an enabled low drive pulls down, else the field feed holds the pin
  assign pin_level = ext_level & ~(drv_oe & ~drv_out);
endmodule
`default_nettype wire

// ===== dv/idc_io_top_tb.sv
`timescale 1ns/10ps
`default_nettype none
module idc_io_top_tb;
  import idc_pkg::*;
  typedef struct {string nm; int sel; int b; logic [31:0] exp;} idc_note_s;
  // Stimulus, host drive stays low while groups are inputs
  logic        clk = 1'b0, rst_b = 1'b0, l5 = 1'b0, pwm_ok = 1'b0;
  logic [31:0] ext = '0, plug = '0, shrt = '0, lvl = '0;
  logic [7:0]  ov = '0, ot = '0, gdir = '0;
  logic [3:0]  mux = '0, addr = '0;
  logic [1:0]  route = '0, ack = '0, run = '0, we = '0;
  logic [1:0]  tin = '0, tclr = '0;
  logic [2:0]  rsel = '0;
  logic [15:0] een = '0, erise = '0;
  idc_entry_s  ent = '0;
  // Observed outputs
  logic [31:0] pin, p_out, p_oe, rd, grn, red;
  logic [7:0]  pa1, pa2;
  logic [15:0] tv1, tv2, pc1, pc2;
  logic [3:0]  f1, f2;
  logic [1:0]  pend;
  logic        i1, i5;
  int          bad_count = 0;
  int          check_count = 0;
  idc_note_s   q[$];
  event        look;

  // Clock
  always #12.5 clk = ~clk;

  idc_io_top DUT
  (
    .clk(clk), .rst_b(rst_b), .field_channel_pin_in(pin), .field_channel_pin_out(p_out),
    .field_channel_pin_oe(p_oe), .test_plug_in(plug), .drv_short(shrt), .drv_overvolt(ov),
    .drv_overtemp(ot), .mux_select(mux), .irq_level_five(l5), .pp_irq_route(route),
    .grp_dir_out(gdir), .host_out_level(lvl), .edge_enable(een), .edge_rising(erise),
    .int_ack(ack), .timer_count_in(tin), .timer_clear(tclr), .timer_value_one(tv1),
    .timer_value_two(tv2), .pp_run(run), .pp_tbl_we(we), .pp_tbl_addr(addr), .pp_tbl_data(ent),
    .pp_rd_sel(rsel), .pp_count_one(pc1), .pp_count_two(pc2), .chan_read(rd),
    .edge_input_controller_one_port_a(pa1), .edge_input_controller_two_port_a(pa2),
    .edge_input_controller_one_fault(f1), .edge_input_controller_two_fault(f2),
    .int_pending(pend), .host_irq1_b(i1), .host_irq5_b(i5), .led_green(grn), .led_red(red)
  );

  idc_field_model FAR (.drv_out(p_out), .drv_oe(p_oe), .ext_level(ext), .pin_level(pin));

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Record an expectation and wake the monitor once outputs settle
  task automatic note(input string nm, input int sel, input int b, input logic [31:0] e);
    q.push_back('{nm, sel, b, e});
    -> look;
  endtask

  function automatic logic [31:0] got(input int s, input int b);
    case (s)
      0: return rd;
      1: return 32'({pa2, pa1});
      2: return 32'({f2, f1});
      3: return 32'(pend);
      4: return 32'({i5, i1});
      5: return 32'(p_out[b]);
      6: return 32'(p_oe[b]);
      7: return grn;
      8: return red;
      10: return {tv2, tv1};
      11: return {pc2, pc1};
      default: return 32'(pwm_ok);
    endcase
  endfunction

  task automatic cmp_v(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic put(input int u, input idc_entry_s e);
    @(posedge clk);
    we <= 2'h1 << u;
    ent <= e;
    @(posedge clk);
    we <= 2'h0;
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Monitor takes the oldest notes and compares them
  initial
  forever
  begin
    idc_note_s n;
    @look;
    #1;
    while (q.size() > 0)
    begin
      n = q.pop_front();
      cmp_v(n.nm, n.exp, got(n.sel, n.b));
    end
  end

  // Watchdog
  initial
  begin
    tick(20000);
    bad_count++;
    close_out();
  end

  // Main sequence
  initial
  begin
    logic [31:0] r;
    logic [31:0] p;
    int k;
    int c;
    int u;
    int hi;
    int n;
    r = $urandom(32'h3E194A4D);
    tick(5);
    rst_b <= 1'b1;
    tick(1);
    note("irq_b", 4, 0, 32'h3);
    note("pending", 3, 0, 32'h0);
    $display("reset test done");
    // Count pulses on both timer inputs, two clocks high and two low, then clear
    n = $urandom_range(8, 1);
    repeat (n)
    begin
      tin <= 2'h3;
      tick(2);
      tin <= 2'h0;
      tick(2);
    end
    tick(2);
    note("timer", 10, 0, {16'(n), 16'(n)});
    tclr <= 2'h3;
    @(posedge clk);
    tclr <= 2'h0;
    @(posedge clk);
    note("timer", 10, 0, 32'h0);
    $display("timer test done");
    // Random inputs with random plugs
    for (k = 0; k < 4; k++)
    begin
      @(posedge clk);
      r = $urandom();
      p = ($urandom() & $urandom()) | 32'h00001000;
      ext <= r;
      plug <= p;
      tick(3);
      note("chan_read", 0, 0, r | p);
    end
    plug <= '0;
    tick(3);
    note("led_green", 7, 0, r);
    note("led_red", 8, 0, 32'h0);
    $display("input test done");
    // Both edge polarities on both request levels, then acknowledge
    ext <= '0;
    tick(4);
    een <= 16'hFFFF;
    for (k = 0; k < 4; k++)
    begin
      erise <= {16{k % 2 == 0}};
      l5 <= (k > 1);
      tick(4);
      ext <= (k % 2 == 0) ? '1 : '0;
      tick(3);
      note("pending", 3, 0, 32'h3);
      note("irq_b", 4, 0, (k > 1) ? 32'h1 : 32'h2);
      note("port_a", 1, 0, (k % 2 == 0) ? 32'hFFFF : 32'h0);
      @(posedge clk);
      ack <= 2'h3;
      @(posedge clk);
      ack <= 2'h0;
      note("pending", 3, 0, 32'h0);
      note("irq_b", 4, 0, 32'h3);
    end
    // Halted pulse units replace bit seven when routed
    een <= '0;
    route <= 2'h3;
    ext <= '1;
    tick(3);
    note("port_a", 1, 0, 32'h7F7F);
    route <= 2'h0;
    $display("interrupt test done");
    // Short and plug mask per group, overtemperature on even and overvoltage on odd groups
    gdir <= '1;
    mux <= 4'hF;
    lvl <= '1;
    for (k = 0; k < 8; k++)
    begin
      c = k * 4 + $urandom_range(3);
      shrt <= 32'h1 << c;
      tick(3);
      note("fault", 2, 0, 32'h1 << k);
      plug <= 32'h1 << c;
      tick(3);
      note("fault", 2, 0, 32'h0);
      plug <= '0;
      shrt <= '0;
      ot <= (k % 2 == 0) ? 8'h1 << k : 8'h0;
      ov <= (k % 2 == 1) ? 8'h1 << k : 8'h0;
      tick(4);
      note("fault", 2, 0, 32'h1 << k);
      ot <= '0;
      ov <= '0;
      tick(3);
    end
    $display("fault test done");
    // Plain and modulated drive from each pulse unit
    run <= 2'h3;
    for (u = 0; u < 2; u++)
    begin
      c = $urandom_range(7);
      put(u, '{1'b1, idc_mode_plain, 3'(c), 16'h0004, 16'h0001});
      tick(40);
      note("pulse_out", 5, u * 16 + c, 32'h1);
      note("pulse_oe", 6, u * 16 + c, 32'h1);
      put(u, '{1'b1, idc_mode_pwm, 3'(c), 16'h0004, 16'h0002});
      hi = 0;
      repeat (256)
      begin
        @(posedge clk);
        hi += p_out[u * 16 + c];
      end
      pwm_ok = (hi >= 96 && hi <= 160);
      note("pwm_half", 9, 0, 32'h1);
      put(u, '{1'b1, idc_mode_plain, 3'(c), 16'h0004, 16'h0000});
      tick(40);
      note("pulse_out", 5, u * 16 + c, 32'h0);
      mux <= 4'h0;
      tick(4);
      note("pulse_oe", 6, u * 16 + c, 32'h0);
      mux <= 4'hF;
    end
    $display("pulse test done");
    // Mid-run reset, then count field pulses on one pulse unit input
    rst_b <= 1'b0;
    mux <= 4'h0;
    tick(2);
    rst_b <= 1'b1;
    ext <= '0;
    rsel <= 3'(c);
    put(0, '{1'b1, idc_mode_count, 3'(c), 16'h00FF, 16'h0000});
    n = $urandom_range(8, 1);
    repeat (n)
    begin
      ext[c] <= 1'b1;
      tick(20);
      ext[c] <= 1'b0;
      tick(20);
    end
    note("pp_count", 11, 0, 32'(n));
    $display("count test done");
    tick(2);
    close_out();
  end
endmodule
`default_nettype wire
